// >>> lpb_arb_model.sv
// secondary bus arbiter model: other masters hold the bus for stall_in
// clocks at a time; assumes the bridge's request blocks new grants
`timescale 1ns/1ns
module lpb_arb_model (
    input  wire logic       ref_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       comp_req_in,
    input  wire logic [3:0] stall_in,
    output logic            bus_idle_out
);
    logic [3:0] busy_r;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in)
            busy_r <= 4'h0;
        else if (busy_r != 4'h0)
            busy_r <= busy_r - 4'h1;
        else if (!comp_req_in)
            busy_r <= stall_in; // no new grant once requested
    end
    assign bus_idle_out = (busy_r == 4'h0);
endmodule : lpb_arb_model

// >>> lpb_bridge.sv
// downstream decode, attribute translation and compensation update control
// assumes all inputs are synchronous to ref_clk_in, which is the bus clock
`timescale 1ns/1ns

// Notes on behaviour
// [RL1] upstream traffic from the secondary side is never claimed
// [RL2] claim downstream memory and io inside the programmed windows
// [RL3] claim config cycles to own function or buses behind the bridge
// [RL4] every end-of-interrupt broadcast not from the secondary side and without the legacy flag is claimed and forwarded
// [RL5] legacy flagged packets claimed for first bridge only when enabled
// [RL6] cacheline-wrap requests are disconnected at the first data phase
// [RL7] config to device 31 on secondary bus becomes a special cycle
// [RL8] config cycles seen on the secondary bus are never claimed
// [RL9] type 1 to type 0 maps device n to ad bit 16+n, 16..30 invalid
// [RL10] coherent low only for pci-x no-snoop upstream memory requests
// [RL11] downstream requests always carry no-snoop cleared
// [RL12] downstream read with cmd bit 3 or passpw response sets relaxed
// [RL13] downstream posted writes always have relaxed ordering cleared
// [RL14] upstream relaxed read sets cmd bit 3, relaxed split sets passpw; the code sets cmd bit 3 in pci-x mode only
// [RL15] immediate answer to a cmd bit 3 read returns passpw set
// [RL16] upstream posted writes go out with passpw cleared
// [RL17] device-specific error completion returns target abort to link
// [RL18] devsel uses medium timing in pci mode and timing b in pci-x
// [RL19] io crossing a dword boundary is master aborted, not issued
// [RL20] check compensation after reset, on override write, every 16 ms
// [RL21] on change, hold bus idle 2 clocks before and 4 after loading
// [RL22] drive the fixed pattern onto ad during the whole idle interval
// [RL23] wait for arbiter idle before the interval, release afterwards
module lpb_bridge #(
    parameter int COMP_PERIOD_CYC = lpb_pkg::COMP_PERIOD_CYC
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rstn_in,
    input  wire lpb_pkg::lpb_win_type      win_in,
    input  wire lpb_pkg::lpb_dn_type       dn_in,
    input  wire lpb_pkg::lpb_up_type       up_in,
    input  wire lpb_pkg::lpb_cpl_type      cpl_in,
    input  wire logic [lpb_pkg::COMP_W-1:0] comp_val_in,
    input  wire logic                      comp_ovr_wr_in,
    input  wire logic                      bus_idle_in,
    output lpb_pkg::lpb_dno_type           dn_out,
    output lpb_pkg::lpb_upo_type           up_link_out,
    output lpb_pkg::lpb_rsp_type           rsp_link_out,
    output logic                           comp_req_out,
    output logic                           ad_oe_out,
    output logic [63:0]                    ad_out,
    output logic                           phy_load_out,
    output logic [lpb_pkg::COMP_W-1:0]     phy_val_out
);

    localparam logic [lpb_pkg::TMR_W-1:0] PERIOD_LD =
        lpb_pkg::TMR_W'(COMP_PERIOD_CYC - 1);
    localparam logic [lpb_pkg::TMR_W-1:0] START_LD =
        lpb_pkg::TMR_W'(lpb_pkg::COMP_START_CYC - 1);
    localparam logic [2:0] PRE_LD  = 3'(lpb_pkg::PRE_IDLE_CYC - 1);
    localparam logic [2:0] POST_LD = 3'(lpb_pkg::POST_IDLE_CYC - 1);
    localparam logic [lpb_pkg::TMR_W-1:0] TMR_ZERO = '0;

    lpb_pkg::lpb_st_type st_r;
    lpb_pkg::lpb_st_type st_nxt;

    logic mem_hit;
    logic io_hit;
    logic cfg_own;
    logic cfg_behind;
    logic cfg_sec;
    logic legacy;
    logic io_cross;
    logic claim;
    logic bad_dev;

    always_comb begin
        mem_hit    = 1'b0;
        io_hit     = 1'b0;
        cfg_own    = 1'b0;
        cfg_behind = 1'b0;
        cfg_sec    = 1'b0;
        legacy     = 1'b0;
        io_cross   = 1'b0;
        claim      = 1'b0;
        bad_dev    = 1'b0;
        st_nxt     = st_r;

        // window hits, 32-bit windows only
        mem_hit = (dn_in.cmd == lpb_pkg::LPB_MEM)
                  && (dn_in.addr[63:32] == 32'h0000_0000)
                  && (dn_in.addr[31:0] >= win_in.mem_base)
                  && (dn_in.addr[31:0] <= win_in.mem_lim); // [RL2]
        io_hit  = (dn_in.cmd == lpb_pkg::LPB_IO)
                  && (dn_in.addr[63:32] == 32'h0000_0000)
                  && (dn_in.addr[31:0] >= win_in.io_base)
                  && (dn_in.addr[31:0] <= win_in.io_lim); // [RL2]
        cfg_own    = (dn_in.cmd == lpb_pkg::LPB_CFG) && !dn_in.cfg_t1
                     && (dn_in.dev == win_in.own_dev); // [RL3]
        cfg_behind = (dn_in.cmd == lpb_pkg::LPB_CFG) && dn_in.cfg_t1
                     && (dn_in.bus >= win_in.sec_bus)
                     && (dn_in.bus <= win_in.sub_bus); // [RL3]
        cfg_sec    = cfg_behind && (dn_in.bus == win_in.sec_bus);

        if (dn_in.legacy_route_a) begin
            // flagged packets belong to the tunnel unless legacy routing
            legacy = win_in.legacy_route_a_en
                     && ((dn_in.cmd == lpb_pkg::LPB_MEM)
                     || (dn_in.cmd == lpb_pkg::LPB_IO)
                     || (dn_in.cmd == lpb_pkg::LPB_IACK)); // [RL5]
            claim  = legacy; // [RL5]
        end else begin
            claim = mem_hit || io_hit || cfg_own || cfg_behind
                    || (dn_in.cmd == lpb_pkg::LPB_EOI); // [RL2] [RL3] [RL4]
        end
        // nothing arriving from the secondary side is ever claimed
        claim = claim && dn_in.valid && !dn_in.from_sec; // [RL1] [RL8]

        io_cross = (dn_in.cmd == lpb_pkg::LPB_IO)
                   && (({3'h0, dn_in.addr[1:0]} + {1'b0, dn_in.nbytes})
                   > lpb_pkg::DW_BYTES); // [RL19]
        bad_dev  = cfg_sec && dn_in.dev[4]
                   && (dn_in.dev != lpb_pkg::SPECIAL_DEV); // [RL9]

        st_nxt.dn.valid      = dn_in.valid;
        st_nxt.dn.claim      = claim;
        st_nxt.dn.to_first   = claim && legacy; // [RL5]
        st_nxt.dn.eoi        = claim
                               && (dn_in.cmd == lpb_pkg::LPB_EOI); // [RL4]
        st_nxt.dn.special    = claim && cfg_sec
                               && (dn_in.dev == lpb_pkg::SPECIAL_DEV); // [RL7]
        st_nxt.dn.cfg0       = claim && cfg_sec && !dn_in.dev[4]; // [RL9]
        st_nxt.dn.idsel      = 32'h0000_0000;
        if (claim && cfg_sec && !dn_in.dev[4]) begin
            st_nxt.dn.idsel = lpb_pkg::IDSEL_ONE
                              << (lpb_pkg::IDSEL_BIT0
                              + int'(dn_in.dev[3:0])); // [RL9]
        end
        // invalid device numbers and dword crossers get a master abort
        st_nxt.dn.ma_resp    = claim && (io_cross || bad_dev); // [RL19]
        st_nxt.dn.issue      = claim && !io_cross && !bad_dev
                               && (dn_in.cmd != lpb_pkg::LPB_EOI); // [RL19]
        st_nxt.dn.ro         = !dn_in.posted
                               && ((dn_in.is_rd && dn_in.cmd3)
                               || (dn_in.is_resp && dn_in.passpw)); // [RL12] [RL13]
        st_nxt.dn.ns         = 1'b0; // [RL11]
        st_nxt.dn.disc_first = claim && dn_in.wrap; // [RL6]
        st_nxt.dn.dsel_b     = win_in.pcix_mode; // [RL18]

        // upstream path: translated onto the link, never decoded here
        st_nxt.up.valid    = up_in.valid; // [RL1]
        st_nxt.up.coherent = !(win_in.pcix_mode && up_in.ns
                             && (up_in.mem_rd || up_in.mem_wr)); // [RL10]
        st_nxt.up.cmd3     = win_in.pcix_mode && up_in.mem_rd
                             && up_in.ro; // [RL14]
        st_nxt.up.passpw   = !up_in.posted && up_in.split
                             && up_in.ro; // [RL14] [RL16]

        // link responses for completions from the secondary bus
        st_nxt.rsp.valid  = cpl_in.valid;
        st_nxt.rsp.err    = cpl_in.valid && cpl_in.dse; // [RL17]
        st_nxt.rsp.nxa    = 1'b0; // [RL17]
        st_nxt.rsp.passpw = cpl_in.valid && cpl_in.imm
                            && cpl_in.cmd3; // [RL15]

        // free-running period timer; a check request stays until served
        if (st_r.tmr == TMR_ZERO) begin
            st_nxt.tmr = PERIOD_LD;
            st_nxt.chk = 1'b1; // [RL20]
        end else begin
            st_nxt.tmr = st_r.tmr - 1'b1;
        end
        if (comp_ovr_wr_in) begin
            st_nxt.chk = 1'b1; // [RL20]
        end

        st_nxt.load = 1'b0;
        case (st_r.ck)
            lpb_pkg::CK_WAIT: begin
                if (st_r.chk) begin
                    // a new request in this cycle is kept, not lost
                    st_nxt.chk = (st_r.tmr == TMR_ZERO) || comp_ovr_wr_in;
                    if (comp_val_in != st_r.applied) begin
                        st_nxt.pend = comp_val_in;
                        st_nxt.req  = 1'b1; // [RL21]
                        st_nxt.ck   = lpb_pkg::CK_REQ;
                    end // else nothing until the next period or override write [RL20]
                end
            end
            lpb_pkg::CK_REQ: begin
                // arbiter must report no transaction before we drive ad
                if (bus_idle_in) begin
                    st_nxt.oe  = 1'b1; // [RL22] [RL23]
                    st_nxt.cnt = PRE_LD; // [RL21]
                    st_nxt.ck  = lpb_pkg::CK_PRE;
                end
            end
            lpb_pkg::CK_PRE: begin
                if (st_r.cnt == lpb_pkg::CNT_ZERO) begin
                    st_nxt.load    = 1'b1; // [RL21]
                    st_nxt.applied = st_r.pend;
                    st_nxt.ck      = lpb_pkg::CK_LOAD;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            lpb_pkg::CK_LOAD: begin
                st_nxt.cnt = POST_LD; // [RL21]
                st_nxt.ck  = lpb_pkg::CK_POST;
            end
            lpb_pkg::CK_POST: begin
                if (st_r.cnt == lpb_pkg::CNT_ZERO) begin
                    st_nxt.oe  = 1'b0; // [RL22]
                    st_nxt.req = 1'b0; // [RL23]
                    st_nxt.ck  = lpb_pkg::CK_WAIT;
                end else begin
                    st_nxt.cnt = st_r.cnt - 1'b1;
                end
            end
            default: begin
                st_nxt.ck  = lpb_pkg::CK_WAIT;
                st_nxt.oe  = 1'b0;
                st_nxt.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r         <= '0;
            st_r.ck      <= lpb_pkg::CK_WAIT;
            st_r.tmr     <= START_LD; // [RL20]
            st_r.up.coherent <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dn_out       = st_r.dn;
    assign up_link_out  = st_r.up;
    assign rsp_link_out = st_r.rsp;
    assign comp_req_out = st_r.req;
    assign ad_oe_out    = st_r.oe;
    // pattern is constant, only the enable moves
    assign ad_out       = lpb_pkg::IDLE_AD; // [RL22]
    assign phy_load_out = st_r.load;
    assign phy_val_out  = st_r.applied;

endmodule : lpb_bridge

// >>> lpb_bridge_assertions.sv
// port-level checks for the link to pci-x decode block
// assumes bind onto lpb_bridge; one clock domain, async low reset
`timescale 1ns/1ns
module lpb_bridge_assertions #(
    parameter int COMP_PERIOD_CYC = 64
) (
    input wire logic                 ref_clk_in,
    input wire logic                 rstn_in,
    input wire lpb_pkg::lpb_win_type win_in,
    input wire lpb_pkg::lpb_dn_type  dn_in,
    input wire lpb_pkg::lpb_up_type  up_in,
    input wire lpb_pkg::lpb_cpl_type cpl_in,
    input wire logic                 bus_idle_in,
    input wire lpb_pkg::lpb_dno_type dn_out,
    input wire lpb_pkg::lpb_upo_type up_link_out,
    input wire lpb_pkg::lpb_rsp_type rsp_link_out,
    input wire logic                 comp_req_out,
    input wire logic                 ad_oe_out,
    input wire logic [63:0]          ad_out,
    input wire logic                 phy_load_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence pre_idle;
        ad_oe_out [*2];
    endsequence
    sequence post_idle;
        ad_oe_out [*4];
    endsequence

    AST_NO_UPSTREAM: assert property (
        dn_in.valid && dn_in.from_sec |=> !dn_out.claim)
        else $error("upstream packet claimed");
    AST_EOI_FWD: assert property (
        dn_in.valid && !dn_in.from_sec && dn_in.cmd == lpb_pkg::LPB_EOI
        |=> dn_out.claim && dn_out.eoi)
        else $error("end of interrupt not forwarded");
    AST_POSTED_RO: assert property (
        dn_in.valid && dn_in.posted && !dn_in.is_resp |=> !dn_out.ro)
        else $error("posted write carries relaxed ordering");
    AST_DSEL: assert property (
        dn_in.valid |=> !dn_out.claim
        || dn_out.dsel_b == $past(win_in.pcix_mode))
        else $error("decode timing does not follow bus mode");
    AST_COHERENT: assert property (
        up_in.valid |=> up_link_out.coherent == !($past(win_in.pcix_mode)
        && $past(up_in.ns) && ($past(up_in.mem_rd) || $past(up_in.mem_wr))))
        else $error("coherent bit wrong");
    AST_UP_POSTED: assert property (
        up_in.valid && up_in.posted |=> !up_link_out.passpw)
        else $error("upstream posted write has passpw");
    AST_DSE_ABORT: assert property (
        cpl_in.valid && cpl_in.dse |=> rsp_link_out.err && !rsp_link_out.nxa)
        else $error("device error not returned as target abort");
    AST_PRE_IDLE: assert property (
        $rose(phy_load_out) |-> $past(ad_oe_out, 2) && $past(ad_oe_out))
        else $error("fewer than two idle cycles before load");
    AST_POST_IDLE: assert property (
        phy_load_out |-> ad_oe_out ##1 post_idle)
        else $error("fewer than four idle cycles after load");
    AST_PATTERN: assert property (
        ad_oe_out |-> ad_out == lpb_pkg::IDLE_AD && comp_req_out)
        else $error("idle pattern missing on ad");
    AST_ARB_IDLE: assert property (
        $rose(ad_oe_out) |-> $past(bus_idle_in) && $past(comp_req_out))
        else $error("idle interval began without arbiter idle");
    cover property (pre_idle ##1 phy_load_out);
endmodule : lpb_bridge_assertions

bind lpb_bridge lpb_bridge_assertions #(
    .COMP_PERIOD_CYC(COMP_PERIOD_CYC)
) i_chk (.ref_clk_in, .rstn_in, .win_in, .dn_in, .up_in, .cpl_in,
    .bus_idle_in, .dn_out, .up_link_out, .rsp_link_out, .comp_req_out,
    .ad_oe_out, .ad_out, .phy_load_out);

// >>> lpb_bridge_tb_top.sv
// self-checking bench for lpb_bridge with a short compensation period
// assumes lpb_pkg, the arbiter model and the bound checker are compiled
`timescale 1ns/1ns
module lpb_bridge_tb_top;
    localparam int PER = 64;
    logic                 ref_clk_in = 1'b0;
    logic                 rstn_in = 1'b0;
    lpb_pkg::lpb_win_type win_in;
    lpb_pkg::lpb_dn_type  dn_in;
    lpb_pkg::lpb_up_type  up_in;
    lpb_pkg::lpb_cpl_type cpl_in;
    logic [15:0]          comp_val_in;
    logic                 comp_ovr_wr_in;
    logic                 bus_idle_in;
    logic [3:0]           stall;
    lpb_pkg::lpb_dno_type dn_out;
    lpb_pkg::lpb_upo_type up_link_out;
    lpb_pkg::lpb_rsp_type rsp_link_out;
    logic                 comp_req_out, ad_oe_out, phy_load_out;
    logic [63:0]          ad_out;
    logic [15:0]          phy_val_out;
    int                   n_fail = 0;
    int                   checks_done = 0;
    int                   n_load = 0;
    int                   cyc = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    lpb_bridge #(.COMP_PERIOD_CYC(PER)) i_dut (.ref_clk_in, .rstn_in,
        .win_in, .dn_in, .up_in, .cpl_in, .comp_val_in, .comp_ovr_wr_in,
        .bus_idle_in, .dn_out, .up_link_out, .rsp_link_out, .comp_req_out,
        .ad_oe_out, .ad_out, .phy_load_out, .phy_val_out);
    lpb_arb_model i_arb (.ref_clk_in, .rstn_in, .comp_req_in(comp_req_out),
        .stall_in(stall), .bus_idle_out(bus_idle_in));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_b

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_w

    function automatic lpb_pkg::lpb_dn_type mk(input lpb_pkg::lpb_cmd_type c,
                                               input logic [31:0] a);
        mk = '0;
        mk.valid = 1'b1;
        mk.cmd = c;
        mk.addr = {32'h0000_0000, a};
        mk.nbytes = 4'h4;
    endfunction : mk

    // one packet per call; valid drops for a cycle before the next one
    task automatic send(input lpb_pkg::lpb_dn_type d,
                        input lpb_pkg::lpb_up_type u,
                        input lpb_pkg::lpb_cpl_type c);
        @(negedge ref_clk_in);
        dn_in = d;
        up_in = u;
        cpl_in = c;
        @(negedge ref_clk_in);
        dn_in = '0;
        up_in = '0;
        cpl_in = '0;
    endtask : send

    task automatic watch(input int lim, output int oe);
        oe = 0;
        repeat (lim) begin
            @(negedge ref_clk_in);
            if (phy_load_out === 1'b1)
                n_load++;
            if (ad_oe_out === 1'b1) begin
                oe++;
                chk_b(comp_req_out, 1'b1);
                chk_w(ad_out[63:32], 32'h0123_4567);
                chk_w(ad_out[31:0], 32'h89ab_cdef);
            end
        end
    endtask : watch

    task automatic t_comp;
        int oe;
        watch(PER + 30, oe);
        chk_w(oe, 32'h0000_0000);
        chk_w(n_load, 32'h0000_0000);
        stall = 4'h9;
        comp_val_in = 16'h00a5;
        @(negedge ref_clk_in);
        comp_ovr_wr_in = 1'b1;
        @(negedge ref_clk_in);
        comp_ovr_wr_in = 1'b0;
        watch(40, oe);
        chk_w(oe, 32'h0000_0007);
        chk_w(n_load, 32'h0000_0001);
        chk_w({16'h0000, phy_val_out}, 32'h0000_00a5);
        comp_val_in = 16'h5a00;
        watch(PER + 40, oe);
        chk_w(oe, 32'h0000_0007);
        chk_w(n_load, 32'h0000_0002);
        chk_w({16'h0000, phy_val_out}, 32'h0000_5a00);
    endtask : t_comp

    task automatic t_claim;
        lpb_pkg::lpb_dn_type d;
        d = mk(lpb_pkg::LPB_MEM, 32'h1000_0000);
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b1);
        chk_b(dn_out.valid, 1'b1);
        d.addr = 64'h0000_0000_2000_0000;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b0);
        d = mk(lpb_pkg::LPB_IO, 32'h0000_1002);
        send(d, '0, '0);
        chk_b(dn_out.ma_resp, 1'b1);
        chk_b(dn_out.issue, 1'b0);
        d.addr = 64'h0000_0000_0000_1000;
        d.from_sec = 1'b1;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b0);
        send(mk(lpb_pkg::LPB_EOI, 32'h0000_0000), '0, '0);
        chk_b(dn_out.eoi, 1'b1);
        d = mk(lpb_pkg::LPB_IACK, 32'h0000_0000);
        d.legacy_route_a = 1'b1;
        send(d, '0, '0);
        chk_b(dn_out.to_first, 1'b1);
        win_in.legacy_route_a_en = 1'b0;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b0);
        win_in.legacy_route_a_en = 1'b1;
    endtask : t_claim

    task automatic t_cfg;
        lpb_pkg::lpb_dn_type d;
        d = mk(lpb_pkg::LPB_CFG, 32'h0000_0000);
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b1);
        d.cfg_t1 = 1'b1;
        d.bus = 8'h02;
        d.dev = 5'h03;
        send(d, '0, '0);
        chk_b(dn_out.cfg0, 1'b1);
        chk_w(dn_out.idsel, 32'h0008_0000);
        d.dev = 5'h10;
        send(d, '0, '0);
        chk_b(dn_out.issue, 1'b0);
        d.dev = 5'h1f;
        send(d, '0, '0);
        chk_b(dn_out.special, 1'b1);
        d.from_sec = 1'b1;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b0);
        d.from_sec = 1'b0;
        d.bus = 8'h05;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b1);
        d.bus = 8'h06;
        send(d, '0, '0);
        chk_b(dn_out.claim, 1'b0);
    endtask : t_cfg

    task automatic t_attr;
        lpb_pkg::lpb_dn_type d;
        d = mk(lpb_pkg::LPB_MEM, 32'h1000_0040);
        d.is_rd = 1'b1;
        d.cmd3 = 1'b1;
        send(d, 7'h63, 4'hc); // no-snoop relaxed read, device error
        chk_b(dn_out.ro, 1'b1);
        chk_b(dn_out.ns, 1'b0);
        chk_b(up_link_out.coherent, 1'b0);
        chk_b(up_link_out.cmd3, 1'b1);
        chk_b(rsp_link_out.err, 1'b1);
        chk_b(rsp_link_out.nxa, 1'b0);
        chk_b(rsp_link_out.valid, 1'b1);
        chk_b(up_link_out.valid, 1'b1);
        d = mk(lpb_pkg::LPB_MEM, 32'h1000_0100);
        d.is_resp = 1'b1;
        d.passpw = 1'b1;
        send(d, '0, '0); // response with passpw
        chk_b(dn_out.ro, 1'b1);
        d = mk(lpb_pkg::LPB_MEM, 32'h1000_0080);
        d.posted = 1'b1;
        d.passpw = 1'b1;
        send(d, 7'h59, 4'hb); // relaxed posted write, immediate answer
        chk_b(dn_out.ro, 1'b0);
        chk_b(up_link_out.passpw, 1'b0);
        chk_b(rsp_link_out.passpw, 1'b1);
        d = mk(lpb_pkg::LPB_MEM, 32'h1000_00c0);
        d.wrap = 1'b1;
        send(d, 7'h45, '0); // relaxed split completion
        chk_b(dn_out.disc_first, 1'b1);
        chk_b(dn_out.dsel_b, 1'b1);
        chk_b(up_link_out.passpw, 1'b1);
        win_in.pcix_mode = 1'b0;
        send(d, 7'h63, '0);
        chk_b(dn_out.dsel_b, 1'b0);
        chk_b(up_link_out.coherent, 1'b1);
    endtask : t_attr

    // hang guard: the whole run needs about 280 cycles
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        win_in = '{32'h1000_0000, 32'h1fff_ffff, 32'h0000_1000,
                   32'h0000_1fff, 8'h02, 8'h05, 5'h00, 1'b1, 1'b1};
        dn_in = '0;
        up_in = '0;
        cpl_in = '0;
        comp_val_in = 16'h0000;
        comp_ovr_wr_in = 1'b0;
        stall = 4'h0;
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rstn_in = 1'b1;
        t_comp();
        t_claim();
        t_cfg();
        t_attr();
        give_verdict();
    end
endmodule : lpb_bridge_tb_top

// >>> lpb_dummy_never.sv
`timescale 1ns/1ns

// >>> lpb_pkg.sv
// constants, types and state layout for the link to pci-x decode block
// assumes one 25 MHz clock that also serves as the secondary bus clock
package lpb_pkg;

    localparam int CLK_KHZ         = 25000;
    localparam int COMP_PERIOD_MS  = 16;
    localparam int COMP_PERIOD_CYC = COMP_PERIOD_MS * CLK_KHZ;
    localparam int COMP_START_CYC  = 16;
    localparam int PRE_IDLE_CYC    = 2;
    localparam int POST_IDLE_CYC   = 4;
    localparam int TMR_W           = 24;
    localparam int COMP_W          = 16;
    localparam int IDSEL_BIT0      = 16;

    localparam logic [63:0] IDLE_AD     = 64'h0123_4567_89ab_cdef;
    localparam logic [4:0]  SPECIAL_DEV = 5'h1f;
    localparam logic [4:0]  DW_BYTES    = 5'h04;
    localparam logic [31:0] IDSEL_ONE   = 32'h0000_0001;
    localparam logic [2:0]  CNT_ZERO    = 3'h0;

    typedef enum logic [2:0] {
        LPB_MEM   = 3'h0,
        LPB_IO    = 3'h1,
        LPB_CFG   = 3'h2,
        LPB_IACK  = 3'h3,
        LPB_EOI   = 3'h4,
        LPB_OTHER = 3'h5
    } lpb_cmd_type;

    typedef enum logic [4:0] {
        CK_WAIT = 5'b00001,
        CK_REQ  = 5'b00010,
        CK_PRE  = 5'b00100,
        CK_LOAD = 5'b01000,
        CK_POST = 5'b10000
    } lpb_ck_type;

    typedef struct packed {
        logic [31:0] mem_base;
        logic [31:0] mem_lim;
        logic [31:0] io_base;
        logic [31:0] io_lim;
        logic [7:0]  sec_bus;
        logic [7:0]  sub_bus;
        logic [4:0]  own_dev;
        logic        legacy_route_a_en;
        logic        pcix_mode;
    } lpb_win_type;

    typedef struct packed {
        logic        valid;
        logic        from_sec;
        lpb_cmd_type cmd;
        logic [63:0] addr;
        logic [3:0]  nbytes;
        logic        legacy_route_a;
        logic        is_rd;
        logic        posted;
        logic        is_resp;
        logic        passpw;
        logic        cmd3;
        logic        wrap;
        logic        cfg_t1;
        logic [7:0]  bus;
        logic [4:0]  dev;
    } lpb_dn_type;

    typedef struct packed {
        logic valid;
        logic mem_rd;
        logic mem_wr;
        logic posted;
        logic split;
        logic ns;
        logic ro;
    } lpb_up_type;

    typedef struct packed {
        logic valid;
        logic dse;
        logic imm;
        logic cmd3;
    } lpb_cpl_type;

    typedef struct packed {
        logic        valid;
        logic        claim;
        logic        issue;
        logic        to_first;
        logic        eoi;
        logic        special;
        logic        cfg0;
        logic [31:0] idsel;
        logic        ro;
        logic        ns;
        logic        disc_first;
        logic        ma_resp;
        logic        dsel_b;
    } lpb_dno_type;

    typedef struct packed {
        logic valid;
        logic coherent;
        logic cmd3;
        logic passpw;
    } lpb_upo_type;

    typedef struct packed {
        logic valid;
        logic err;
        logic nxa;
        logic passpw;
    } lpb_rsp_type;

    typedef struct packed {
        lpb_dno_type       dn;
        lpb_upo_type       up;
        lpb_rsp_type       rsp;
        lpb_ck_type        ck;
        logic [TMR_W-1:0]  tmr;
        logic [2:0]        cnt;
        logic              chk;
        logic [COMP_W-1:0] pend;
        logic [COMP_W-1:0] applied;
        logic              req;
        logic              oe;
        logic              load;
    } lpb_st_type;

endpackage : lpb_pkg
